// file: shared/port_pin_function_control_defines.svh
// Purpose: constants of the port pin function control block
// Assumes: 32-bit APB, one aligned word per register
// Notes: all offsets are byte addresses
// Contract
// - pb7_func 15:14: 00 gpio, 01 timer7 pwm d, 10 timer8 one-shot d
// - pb6_func 13:12: 00 gpio, 01 timer7 pwm c, 10 timer8 one-shot c
// - pb5_func 11:10: 00 gpio, 01 timer7 pwm b, 10 timer8 one-shot b
// - pb4_func 9:8: 00 gpio, 01 timer7 pwm a, 10 timer8 one-shot a
// - pb3_func bit 6: 0 gpio, 1 timer6 pwm d
// - pb2_func bit 4: 0 gpio, 1 timer6 pwm c
// - pb1_func bit 2: 0 gpio, 1 timer6 pwm b
// - pb0_func bit 0: 0 gpio, 1 timer6 pwm a
// - function bits 7, 5, 3, 1 read zero; software writes zero
// - timer or serial clock pin is inverted when its invert bit is 1
// - invert bits do nothing for gpio or other functions
// - invert bits 15..13 and 11..0 writable; bit 12 reads zero
// - port c gpio pin drives out when direction bit 1, input when 0
// - port c direction bits 4..0 writable; bits 15..5 read zero
// - port c direction ignored when pin function is not gpio
// - invert and direction clear on power-on reset and hardware standby
// - invert and direction keep contents in sleep and software standby
// - low function register clears likewise and is kept in sleep
`ifndef PORT_PIN_FUNCTION_CONTROL_DEFINES_SVH
`define PORT_PIN_FUNCTION_CONTROL_DEFINES_SVH
`define OFS_LOW_FUNC 12'h000
`define OFS_INVERT 12'h004
`define OFS_PC_DIR 12'h008
`define LOW_FUNC_WMASK 16'hFF55
`define INVERT_WMASK 16'hEFFF
`define PC_DIR_WMASK 16'h001F
`define REG_RESET 16'h0000
`define FUNC2_GPIO 2'h0
`define FUNC2_PWM 2'h1
`define FUNC2_ONESHOT 2'h2
`define PB7_FUNC_LSB 14
`define PB6_FUNC_LSB 12
`define PB5_FUNC_LSB 10
`define PB4_FUNC_LSB 8
`define PB3_FUNC_BIT 6
`define PB2_FUNC_BIT 4
`define PB1_FUNC_BIT 2
`define PB0_FUNC_BIT 0
`define INVERT_RO_BIT 12
`endif

// file: shared/port_pin_function_control_pkg.sv
// Purpose: types of the port pin function control block
// Assumes: APB3 signalling, no pstrb
// Notes: state struct holds every flop of the block
package port_pin_function_control_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;
  typedef struct packed {
    logic [15:0] port_b_low_function_select;
    logic [15:0] port_b_output_invert;
    logic [15:0] port_c_direction;
    logic stby_meta;
    logic stby_s2;
    logic stby_s3;
    logic stby;
    logic [7:0] pb_lo_out;
    logic [7:0] pb_lo_oe;
    logic [7:0] pb_hi_out;
    logic [4:0] pc_out;
    logic [4:0] pc_oe;
    apb_rsp_s rsp;
  } ctl_state_s;
endpackage : port_pin_function_control_pkg

// file: src/port_pin_function_control.sv
// Purpose: pin function select, output invert and port c direction
// Assumes: rst_b is the non-watchdog power-on reset; timer inputs on core_clk
// Notes: pin outputs lag their inputs by one clock
`timescale 1ns/1ps
`include "port_pin_function_control_defines.svh"
module port_pin_function_control (
  input wire logic core_clk,
  input wire logic rst_b,
  input port_pin_function_control_pkg::apb_req_s apb_req,
  output port_pin_function_control_pkg::apb_rsp_s apb_rsp,
  input wire logic hw_standby,
  input wire logic [7:0] pb_lo_gpio_out,
  input wire logic [7:0] pb_lo_gpio_dir,
  input wire logic [3:0] timer7_pwm_out,
  input wire logic [3:0] timer8_oneshot_out,
  input wire logic [3:0] timer6_pwm_out,
  input wire logic [7:0] pb_hi_func_out,
  input wire logic [7:0] pb_hi_special,
  input wire logic [4:0] pc_func,
  input wire logic [4:0] pc_gpio_out,
  input wire logic [4:0] pc_periph_out,
  input wire logic [4:0] pc_periph_oe,
  output logic [7:0] pb_lo_pin_out,
  output logic [7:0] pb_lo_pin_oe,
  output logic [7:0] pb_hi_pin_out,
  output logic [4:0] pc_pin_out,
  output logic [4:0] pc_pin_oe
);
  import port_pin_function_control_pkg::*;

  ctl_state_s st;
  ctl_state_s next_st;

  always_comb begin
    logic access;
    logic [15:0] rd;
    logic unmapped;
    logic [1:0] code;
    logic [15:0] inv;
    access = 1'b0;
    rd = 16'h0000;
    unmapped = 1'b0;
    code = 2'h0;
    inv = st.port_b_output_invert;
    next_st = st;
    // standby pin is asynchronous; the first stage feeds only the second
    next_st.stby_meta = hw_standby;
    next_st.stby_s2 = st.stby_meta;
    next_st.stby_s3 = st.stby_s2;
    if (st.stby_s2 == st.stby_s3) begin
      next_st.stby = st.stby_s3;
    end
    // apb: ready one cycle into the access phase, so each access takes 3 cycles
    access = apb_req.psel & apb_req.penable & ~st.rsp.pready;
    case (apb_req.paddr)
      `OFS_LOW_FUNC: rd = st.port_b_low_function_select;
      `OFS_INVERT: rd = st.port_b_output_invert;
      `OFS_PC_DIR: rd = st.port_c_direction;
      default: unmapped = 1'b1;
    endcase
    next_st.rsp.pready = access;
    next_st.rsp.pslverr = access & unmapped;
    next_st.rsp.prdata = 32'h0000_0000;
    if (access & ~apb_req.pwrite) begin
      next_st.rsp.prdata = {16'h0000, rd};
    end
    if (access & apb_req.pwrite) begin
      case (apb_req.paddr)
        `OFS_LOW_FUNC: begin
          // read-only bits are masked so they always read back zero
          next_st.port_b_low_function_select =
            apb_req.pwdata[15:0] & `LOW_FUNC_WMASK;
        end
        `OFS_INVERT: begin
          next_st.port_b_output_invert =
            apb_req.pwdata[15:0] & `INVERT_WMASK;
        end
        `OFS_PC_DIR: begin
          next_st.port_c_direction =
            apb_req.pwdata[15:0] & `PC_DIR_WMASK;
        end
        default: begin
        end
      endcase
    end
    // standby clears; sleep and software standby have no input, so all is kept
    if (st.stby) begin
      next_st.port_b_low_function_select = `REG_RESET;
      next_st.port_b_output_invert = `REG_RESET;
      next_st.port_c_direction = `REG_RESET;
    end
    // wide fields of pins 7..4
    for (int i = 0; i < 4; i++) begin
      code = st.port_b_low_function_select[`PB4_FUNC_LSB + 2 * i +: 2];
      case (code)
        `FUNC2_PWM: begin
          next_st.pb_lo_out[4 + i] = timer7_pwm_out[i] ^ inv[4 + i];
          next_st.pb_lo_oe[4 + i] = 1'b1;
        end
        `FUNC2_ONESHOT: begin
          next_st.pb_lo_out[4 + i] = timer8_oneshot_out[i] ^ inv[4 + i];
          next_st.pb_lo_oe[4 + i] = 1'b1;
        end
        default: begin
          // gpio and the reserved code alike: no timer output reaches the pin
          next_st.pb_lo_out[4 + i] = pb_lo_gpio_out[4 + i];
          next_st.pb_lo_oe[4 + i] = pb_lo_gpio_dir[4 + i];
        end
      endcase
    end
    // single-bit fields of pins 3..0 sit on even bits
    for (int i = 0; i < 4; i++) begin
      if (st.port_b_low_function_select[`PB0_FUNC_BIT + 2 * i]) begin
        next_st.pb_lo_out[i] = timer6_pwm_out[i] ^ inv[i];
        next_st.pb_lo_oe[i] = 1'b1;
      end else begin
        next_st.pb_lo_out[i] = pb_lo_gpio_out[i];
        next_st.pb_lo_oe[i] = pb_lo_gpio_dir[i];
      end
    end
    // upper pins: function chosen elsewhere, only the inversion lives here
    for (int i = 0; i < 8; i++) begin
      if (pb_hi_special[i]) begin
        next_st.pb_hi_out[i] = pb_hi_func_out[i] ^ inv[8 + i];
      end else begin
        next_st.pb_hi_out[i] = pb_hi_func_out[i];
      end
    end
    for (int i = 0; i < 5; i++) begin
      if (pc_func[i]) begin
        next_st.pc_out[i] = pc_periph_out[i];
        next_st.pc_oe[i] = pc_periph_oe[i];
      end else begin
        next_st.pc_out[i] = pc_gpio_out[i];
        next_st.pc_oe[i] = st.port_c_direction[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp = st.rsp;
  assign pb_lo_pin_out = st.pb_lo_out;
  assign pb_lo_pin_oe = st.pb_lo_oe;
  assign pb_hi_pin_out = st.pb_hi_out;
  assign pc_pin_out = st.pc_out;
  assign pc_pin_oe = st.pc_oe;

  // register image seen by the checks below; bit 12 is always zero
  logic [15:0] inv_q;
  assign inv_q = st.port_b_output_invert;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_pb7_func;
    st.port_b_low_function_select[15:14] == `FUNC2_ONESHOT
      |=> pb_lo_pin_out[7] == ($past(timer8_oneshot_out[3]) ^ $past(inv_q[7])) && pb_lo_pin_oe[7];
  endproperty
  a_pb7_func: assert property (p_pb7_func) else $error("pin 7 one-shot route wrong");

  property p_pb6_func;
    st.port_b_low_function_select[13:12] == `FUNC2_PWM
      |=> pb_lo_pin_out[6] == ($past(timer7_pwm_out[2]) ^ $past(inv_q[6]));
  endproperty
  a_pb6_func: assert property (p_pb6_func) else $error("pin 6 pwm route wrong");

  property p_pb3_func;
    st.port_b_low_function_select[6]
      |=> pb_lo_pin_out[3] == ($past(timer6_pwm_out[3]) ^ $past(inv_q[3]));
  endproperty
  a_pb3_func: assert property (p_pb3_func) else $error("pin 3 pwm route wrong");

  property p_ro_read;
    st.rsp.pready && !$past(apb_req.pwrite) && $past(apb_req.paddr) == `OFS_LOW_FUNC
      |-> (st.rsp.prdata & 32'h0000_00AA) == 32'h0000_0000;
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("reserved function bit read as one");

  property p_gpio_no_invert;
    st.port_b_low_function_select[`PB0_FUNC_BIT] == 1'b0
      |=> pb_lo_pin_out[0] == $past(pb_lo_gpio_out[0]);
  endproperty
  a_gpio_no_invert: assert property (p_gpio_no_invert) else $error("gpio pin inverted");

  property p_hi_invert;
    pb_hi_special[0] && inv_q[8] |=> pb_hi_pin_out[0] != $past(pb_hi_func_out[0]);
  endproperty
  a_hi_invert: assert property (p_hi_invert) else $error("special pin not inverted");

  property p_bit12_zero;
    st.port_b_output_invert[`INVERT_RO_BIT] == 1'b0 && st.port_c_direction[15:5] == 11'h000;
  endproperty
  a_bit12_zero: assert property (p_bit12_zero) else $error("read-only bit set");

  property p_pc_dir;
    !pc_func[1] |=> pc_pin_oe[1] == $past(st.port_c_direction[1]);
  endproperty
  a_pc_dir: assert property (p_pc_dir) else $error("port c direction not applied");

  property p_pc_ignore;
    pc_func[2] |=> pc_pin_oe[2] == $past(pc_periph_oe[2]);
  endproperty
  a_pc_ignore: assert property (p_pc_ignore) else $error("direction used in function mode");

  property p_standby_clear;
    st.stby |=> st.port_b_output_invert == `REG_RESET && st.port_c_direction == `REG_RESET
      && st.port_b_low_function_select == `REG_RESET;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby did not clear");

  property p_reserved_gpio;
    st.port_b_low_function_select[9:8] == 2'h3 |=> pb_lo_pin_oe[4] == $past(pb_lo_gpio_dir[4]);
  endproperty
  a_reserved_gpio: assert property (p_reserved_gpio) else $error("reserved code drove timer");

  property p_ready_pulse;
    st.rsp.pready |=> !st.rsp.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held two cycles");

  property p_pb7_pwm;
    st.port_b_low_function_select[15:14] == `FUNC2_PWM
      |=> pb_lo_pin_out[7] == ($past(timer7_pwm_out[3]) ^ $past(inv_q[7])) && pb_lo_pin_oe[7];
  endproperty
  a_pb7_pwm: assert property (p_pb7_pwm) else $error("pin 7 pwm route wrong");

  property p_pb6_oneshot;
    st.port_b_low_function_select[13:12] == `FUNC2_ONESHOT
      |=> pb_lo_pin_out[6] == ($past(timer8_oneshot_out[2]) ^ $past(inv_q[6])) && pb_lo_pin_oe[6];
  endproperty
  a_pb6_oneshot: assert property (p_pb6_oneshot) else $error("pin 6 one-shot route wrong");

  property p_pb5_pwm;
    st.port_b_low_function_select[11:10] == `FUNC2_PWM
      |=> pb_lo_pin_out[5] == ($past(timer7_pwm_out[1]) ^ $past(inv_q[5])) && pb_lo_pin_oe[5];
  endproperty
  a_pb5_pwm: assert property (p_pb5_pwm) else $error("pin 5 pwm route wrong");

  property p_pb5_oneshot;
    st.port_b_low_function_select[11:10] == `FUNC2_ONESHOT
      |=> pb_lo_pin_out[5] == ($past(timer8_oneshot_out[1]) ^ $past(inv_q[5])) && pb_lo_pin_oe[5];
  endproperty
  a_pb5_oneshot: assert property (p_pb5_oneshot) else $error("pin 5 one-shot route wrong");

  property p_pb4_pwm;
    st.port_b_low_function_select[9:8] == `FUNC2_PWM
      |=> pb_lo_pin_out[4] == ($past(timer7_pwm_out[0]) ^ $past(inv_q[4])) && pb_lo_pin_oe[4];
  endproperty
  a_pb4_pwm: assert property (p_pb4_pwm) else $error("pin 4 pwm route wrong");

  property p_pb4_oneshot;
    st.port_b_low_function_select[9:8] == `FUNC2_ONESHOT
      |=> pb_lo_pin_out[4] == ($past(timer8_oneshot_out[0]) ^ $past(inv_q[4])) && pb_lo_pin_oe[4];
  endproperty
  a_pb4_oneshot: assert property (p_pb4_oneshot) else $error("pin 4 one-shot route wrong");

  property p_pb2_func;
    st.port_b_low_function_select[`PB2_FUNC_BIT]
      |=> pb_lo_pin_out[2] == ($past(timer6_pwm_out[2]) ^ $past(inv_q[2])) && pb_lo_pin_oe[2];
  endproperty
  a_pb2_func: assert property (p_pb2_func) else $error("pin 2 pwm route wrong");

  property p_pb1_func;
    st.port_b_low_function_select[`PB1_FUNC_BIT]
      |=> pb_lo_pin_out[1] == ($past(timer6_pwm_out[1]) ^ $past(inv_q[1])) && pb_lo_pin_oe[1];
  endproperty
  a_pb1_func: assert property (p_pb1_func) else $error("pin 1 pwm route wrong");

  property p_pb0_func;
    st.port_b_low_function_select[`PB0_FUNC_BIT]
      |=> pb_lo_pin_out[0] == ($past(timer6_pwm_out[0]) ^ $past(inv_q[0])) && pb_lo_pin_oe[0];
  endproperty
  a_pb0_func: assert property (p_pb0_func) else $error("pin 0 pwm route wrong");

  property p_pb7_gpio;
    st.port_b_low_function_select[15:14] == `FUNC2_GPIO
      |=> pb_lo_pin_out[7] == $past(pb_lo_gpio_out[7]) && pb_lo_pin_oe[7] == $past(pb_lo_gpio_dir[7]);
  endproperty
  a_pb7_gpio: assert property (p_pb7_gpio) else $error("pin 7 gpio path wrong");

  property p_pb3_gpio;
    !st.port_b_low_function_select[`PB3_FUNC_BIT]
      |=> pb_lo_pin_out[3] == $past(pb_lo_gpio_out[3]) && pb_lo_pin_oe[3] == $past(pb_lo_gpio_dir[3]);
  endproperty
  a_pb3_gpio: assert property (p_pb3_gpio) else $error("pin 3 gpio path wrong");

  property p_pb6_reserved;
    st.port_b_low_function_select[13:12] == 2'h3
      |=> pb_lo_pin_out[6] == $past(pb_lo_gpio_out[6]) && pb_lo_pin_oe[6] == $past(pb_lo_gpio_dir[6]);
  endproperty
  a_pb6_reserved: assert property (p_pb6_reserved) else $error("reserved code not gpio");

  property p_hi_plain;
    !pb_hi_special[3]
      |=> pb_hi_pin_out[3] == $past(pb_hi_func_out[3]);
  endproperty
  a_hi_plain: assert property (p_hi_plain) else $error("plain upper pin inverted");

  property p_hi_bit12;
    pb_hi_special[4]
      |=> pb_hi_pin_out[4] == $past(pb_hi_func_out[4]);
  endproperty
  a_hi_bit12: assert property (p_hi_bit12) else $error("pin 12 inverted");

  property p_pc_gpio_out;
    !pc_func[0]
      |=> pc_pin_out[0] == $past(pc_gpio_out[0]) && pc_pin_oe[0] == $past(st.port_c_direction[0]);
  endproperty
  a_pc_gpio_out: assert property (p_pc_gpio_out) else $error("port c gpio path wrong");

  property p_pc_periph_out;
    pc_func[4]
      |=> pc_pin_out[4] == $past(pc_periph_out[4]) && pc_pin_oe[4] == $past(pc_periph_oe[4]);
  endproperty
  a_pc_periph_out: assert property (p_pc_periph_out) else $error("port c function path wrong");

  property p_lo_func_ro;
    (st.port_b_low_function_select & ~`LOW_FUNC_WMASK) == 16'h0000;
  endproperty
  a_lo_func_ro: assert property (p_lo_func_ro) else $error("read-only function bit set");

  // a write lands at the first access edge unless standby overrides it
  property p_inv_write;
    st.rsp.pready && $past(apb_req.pwrite) && $past(apb_req.paddr) == `OFS_INVERT && !$past(st.stby)
      |-> st.port_b_output_invert == ($past(apb_req.pwdata[15:0]) & `INVERT_WMASK);
  endproperty
  a_inv_write: assert property (p_inv_write) else $error("invert write lost");

  property p_dir_write;
    st.rsp.pready && $past(apb_req.pwrite) && $past(apb_req.paddr) == `OFS_PC_DIR && !$past(st.stby)
      |-> st.port_c_direction == ($past(apb_req.pwdata[15:0]) & `PC_DIR_WMASK);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_inv_kept;
    !st.stby && !(apb_req.psel && apb_req.penable && apb_req.pwrite && !st.rsp.pready)
      |=> $stable(st.port_b_output_invert);
  endproperty
  a_inv_kept: assert property (p_inv_kept) else $error("invert changed without write");

  property p_dir_kept;
    !st.stby && !(apb_req.psel && apb_req.penable && apb_req.pwrite && !st.rsp.pready)
      |=> $stable(st.port_c_direction);
  endproperty
  a_dir_kept: assert property (p_dir_kept) else $error("direction changed without write");

  property p_func_kept;
    !st.stby && !(apb_req.psel && apb_req.penable && apb_req.pwrite && !st.rsp.pready)
      |=> $stable(st.port_b_low_function_select);
  endproperty
  a_func_kept: assert property (p_func_kept) else $error("function changed without write");

  property p_slverr_ready;
    st.rsp.pslverr
      |-> st.rsp.pready;
  endproperty
  a_slverr_ready: assert property (p_slverr_ready) else $error("pslverr without pready");

  property p_prdata_idle;
    !st.rsp.pready
      |-> st.rsp.prdata == 32'h0000_0000;
  endproperty
  a_prdata_idle: assert property (p_prdata_idle) else $error("prdata outside an answer");

  // standby only moves once the last two sync stages agree
  property p_stby_sync;
    $changed(st.stby)
      |-> st.stby == $past(st.stby_s3) && $past(st.stby_s2) == $past(st.stby_s3);
  endproperty
  a_stby_sync: assert property (p_stby_sync) else $error("standby taken before sync agreed");

  property p_pc_dir_ro;
    st.port_c_direction[15:5] == 11'h000
      |=> st.port_c_direction[15:5] == 11'h000;
  endproperty
  a_pc_dir_ro: assert property (p_pc_dir_ro) else $error("port c read-only bit set");

  c_write_invert: cover property (st.rsp.pready && $past(apb_req.pwrite)
    && $past(apb_req.paddr) == `OFS_INVERT);
  c_oneshot: cover property (st.port_b_low_function_select[15:14] == `FUNC2_ONESHOT);
  c_standby: cover property ($rose(st.stby));
  c_unmapped: cover property (st.rsp.pslverr);
endmodule : port_pin_function_control

// file: bench/port_pin_function_control_test.sv
// Purpose: self-checking bench for the port pin function control block
// Assumes: apb answer within 8 cycles; pin outputs lag their inputs by one clock
// Notes: register images in the bench drive the expected read data and pin values
`timescale 1ns/1ps
`include "port_pin_function_control_defines.svh"
module port_pin_function_control_test;
  import port_pin_function_control_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hw_standby = 1'b0;
  apb_req_s apb_req = '0;
  apb_rsp_s apb_rsp;
  logic [7:0] lo_out = 8'h00, lo_dir = 8'h00, hi_out = 8'h00, hi_spec = 8'h00;
  logic [3:0] t7 = 4'h0, t8 = 4'h0, t6 = 4'h0;
  logic [4:0] pcf = 5'h00, pc_go = 5'h00, pc_po = 5'h00, pc_poe = 5'h00;
  logic [7:0] pb_lo_pin_out, pb_lo_pin_oe, pb_hi_pin_out;
  logic [4:0] pc_pin_out, pc_pin_oe;
  logic [15:0] m_func = 16'h0000, m_inv = 16'h0000, m_dir = 16'h0000;
  integer err_count = 0, check_count = 0, seed = 32'hbe5dcb24, i;
  port_pin_function_control port_pin_function_control_i (
    .core_clk(core_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .hw_standby(hw_standby), .pb_lo_gpio_out(lo_out), .pb_lo_gpio_dir(lo_dir),
    .timer7_pwm_out(t7), .timer8_oneshot_out(t8), .timer6_pwm_out(t6),
    .pb_hi_func_out(hi_out), .pb_hi_special(hi_spec), .pc_func(pcf),
    .pc_gpio_out(pc_go), .pc_periph_out(pc_po), .pc_periph_oe(pc_poe),
    .pb_lo_pin_out(pb_lo_pin_out), .pb_lo_pin_oe(pb_lo_pin_oe),
    .pb_hi_pin_out(pb_hi_pin_out), .pc_pin_out(pc_pin_out), .pc_pin_oe(pc_pin_oe));
  initial forever #4 core_clk = ~core_clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // setup cycle, then access held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk);
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 8);
    if (apb_rsp.pready !== 1'b1) begin
      chk("pready wait", 32'h1, 32'h0);
      finish_test();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb
  function automatic logic unmapped(input logic [11:0] a);
    return a != `OFS_LOW_FUNC && a != `OFS_INVERT && a != `OFS_PC_DIR;
  endfunction : unmapped
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    if (a == `OFS_LOW_FUNC) m_func = d[15:0] & 16'hFF55;
    if (a == `OFS_INVERT) m_inv = d[15:0] & 16'hEFFF;
    if (a == `OFS_PC_DIR) m_dir = d[15:0] & 16'h001F;
    chk("write slverr", {31'h0, unmapped(a)}, {31'h0, err});
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, $random(seed), rd, err);
    chk("read slverr", {31'h0, unmapped(a)}, {31'h0, err});
    chk("read data", a == `OFS_LOW_FUNC ? m_func : a == `OFS_INVERT ? m_inv :
        a == `OFS_PC_DIR ? m_dir : 16'h0000, rd);
  endtask : rd_reg
  task automatic rd_all();
    rd_reg(`OFS_LOW_FUNC);
    rd_reg(`OFS_INVERT);
    rd_reg(`OFS_PC_DIR);
    rd_reg(12'h00C);
  endtask : rd_all
  // new random pin inputs, then compare every pin output with the model
  task automatic pins();
    logic [31:0] r;
    logic [7:0] eo, ee, t1, t2;
    logic [1:0] c;
    int k;
    r = $random(seed);
    @(posedge core_clk);
    {lo_out, lo_dir, hi_out, hi_spec} <= r;
    r = $random(seed);
    {t7, t8, t6, pcf} <= r[16:0];
    r = $random(seed);
    {pc_go, pc_po, pc_poe} <= r[14:0];
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    t1 = {t7, t6};
    t2 = {t8, 4'h0};
    for (k = 0; k < 8; k++) begin
      c = (k < 4) ? {1'b0, m_func[2*k]} : m_func[2*k +: 2];
      eo[k] = lo_out[k];
      ee[k] = lo_dir[k];
      if (c == 2'h1) eo[k] = t1[k] ^ m_inv[k];
      if (c == 2'h2) eo[k] = t2[k] ^ m_inv[k];
      if (c == 2'h1 || c == 2'h2) ee[k] = 1'b1;
    end
    chk("pb low out", {24'h0, eo}, {24'h0, pb_lo_pin_out});
    chk("pb low oe", {24'h0, ee}, {24'h0, pb_lo_pin_oe});
    chk("pb high out", {24'h0, hi_out ^ (hi_spec & m_inv[15:8])},
        {24'h0, pb_hi_pin_out});
    chk("pc out", {27'h0, (pcf & pc_po) | (~pcf & pc_go)}, {27'h0, pc_pin_out});
    chk("pc oe", {27'h0, (pcf & pc_poe) | (~pcf & m_dir[4:0])}, {27'h0, pc_pin_oe});
  endtask : pins
  initial begin
    logic [31:0] d, r;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_all();
    pins();
    $display("test reset_values done");
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      d[15:8] = {4{i[1:0]}}; // code 11 on purpose
      wr_reg(`OFS_LOW_FUNC, d);
      wr_reg(`OFS_INVERT, $random(seed));
      wr_reg(`OFS_PC_DIR, $random(seed));
      pins();
      pins();
      rd_all();
    end
    $display("test function_codes done");
    repeat (30) begin
      d = $random(seed);
      r = $random(seed);
      wr_reg({8'h00, r[1:0], 2'b00}, d);
      rd_reg({8'h00, r[3:2], 2'b00});
      pins();
    end
    $display("test random_traffic done");
    // standby clears all three registers while held; sync delay is covered by the wait
    @(posedge core_clk);
    hw_standby <= 1'b1;
    repeat (6) @(posedge core_clk);
    {m_func, m_inv, m_dir} = 48'h0;
    rd_all();
    pins();
    @(posedge core_clk);
    hw_standby <= 1'b0;
    // the clear lasts until the sync releases; a write before then is lost
    repeat (6) @(posedge core_clk);
    $display("test hw_standby done");
    wr_reg(`OFS_INVERT, 32'hFFFFFFFF);
    wr_reg(`OFS_PC_DIR, 32'hFFFFFFFF);
    rd_all();
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    {m_func, m_inv, m_dir} = 48'h0;
    rd_all();
    pins();
    $display("test mid_reset done");
    finish_test();
  end
endmodule : port_pin_function_control_test
